// ===== core/smbcfg_pkg.sv
// Constants for the SMBus configuration slave.
// Assumes a 100 MHz system clock; serial pins arrive asynchronously.
package smbcfg_pkg;
  localparam logic [6:0] SMBCFG_ADDR_BASE = 7'h50;
  localparam int SMBCFG_ADDR_SEL_LSB = 0;
  localparam logic [7:0] SMBCFG_OFF_SOFT_RESET = 8'h00;
  localparam logic [7:0] SMBCFG_OFF_LANE_POWER_DOWN = 8'h01;
  localparam logic [7:0] SMBCFG_OFF_POWER_DOWN_CTRL = 8'h02;
  localparam int SMBCFG_NUM_DEEMPH = 6;
  localparam logic [7:0] SMBCFG_OFF_DEEMPH [SMBCFG_NUM_DEEMPH] =
    '{8'h18, 8'h26, 8'h2e, 8'h35, 8'h3c, 8'h43};
  localparam logic [7:0] SMBCFG_RST_SOFT_RESET = 8'h00;
  localparam logic [7:0] SMBCFG_RST_LANE_POWER_DOWN = 8'h00;
  localparam logic [7:0] SMBCFG_RST_POWER_DOWN_CTRL = 8'h00;
  localparam logic [7:0] SMBCFG_RST_DEEMPH = 8'h00;
  localparam int SMBCFG_SOFT_RESET_BIT = 0;
  localparam int SMBCFG_POWER_DOWN_ENABLE_BIT = 0;
  localparam logic [7:0] SMBCFG_DE_0DB = 8'h01;
  localparam logic [7:0] SMBCFG_DE_M3P5DB = 8'he8;
  localparam logic [7:0] SMBCFG_DE_M6DB = 8'h88;
  localparam logic [7:0] SMBCFG_DE_M9DB = 8'h90;
  localparam logic [7:0] SMBCFG_DE_M12DB = 8'ha0;
  localparam int SMBCFG_CLK_MHZ = 100;
  localparam int SMBCFG_T_BUF_NS = 4700;
  localparam int SMBCFG_T_HIGH_MAX_NS = 50000;
  localparam int SMBCFG_T_BUF_CYC = (SMBCFG_T_BUF_NS * SMBCFG_CLK_MHZ + 999) / 1000;
  localparam int SMBCFG_T_HIGH_MAX_CYC = (SMBCFG_T_HIGH_MAX_NS * SMBCFG_CLK_MHZ) / 1000;
  localparam logic [7:0] SMBCFG_READ_UNMAPPED = 8'h00;
endpackage : smbcfg_pkg

// ===== core/smbcfg_reg_if.sv
// Register access port between the serial engine and the register file.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface smbcfg_reg_if;
  logic wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport engine (output wr_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface : smbcfg_reg_if

// ===== core/smbcfg_regs.sv
// Configuration registers: soft reset, lane power-down, de-emphasis codes.
// Assumes synchronous write strobes; read data comes out of a register.
`timescale 1ns/1ps
module smbcfg_regs
  import smbcfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Clears everything to defaults while low
  input wire logic mode_enable_i,
  // Access port
  smbcfg_reg_if.regs bus,
  // Effective power-down
  output logic [7:0] power_down_o,
  output logic [7:0] deemph_o [SMBCFG_NUM_DEEMPH]
);
  logic [7:0] lane_power_down_reg;
  logic [7:0] power_down_ctrl_reg;
  logic [7:0] deemph_reg [SMBCFG_NUM_DEEMPH];
  logic [7:0] rdata_reg;
  logic soft_clear;

  assign soft_clear = bus.wr_stb && bus.addr == SMBCFG_OFF_SOFT_RESET &&
                      bus.wdata[SMBCFG_SOFT_RESET_BIT];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lane_power_down_reg <= SMBCFG_RST_LANE_POWER_DOWN;
      power_down_ctrl_reg <= SMBCFG_RST_POWER_DOWN_CTRL;
    end else if (!mode_enable_i || soft_clear) begin
      lane_power_down_reg <= SMBCFG_RST_LANE_POWER_DOWN;
      power_down_ctrl_reg <= SMBCFG_RST_POWER_DOWN_CTRL;
    end else if (bus.wr_stb) begin
      if (bus.addr == SMBCFG_OFF_LANE_POWER_DOWN) begin
        lane_power_down_reg <= bus.wdata;
      end
      if (bus.addr == SMBCFG_OFF_POWER_DOWN_CTRL) begin
        power_down_ctrl_reg <= bus.wdata;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SMBCFG_NUM_DEEMPH; gi++) begin : g_de
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          deemph_reg[gi] <= SMBCFG_RST_DEEMPH;
        end else if (!mode_enable_i || soft_clear) begin
          deemph_reg[gi] <= SMBCFG_RST_DEEMPH;
        end else if (bus.wr_stb && bus.addr == SMBCFG_OFF_DEEMPH[gi]) begin
          deemph_reg[gi] <= bus.wdata;
        end
      end
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          deemph_o[gi] <= SMBCFG_RST_DEEMPH;
        end else begin
          deemph_o[gi] <= deemph_reg[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      power_down_o <= 8'h00;
    end else if (power_down_ctrl_reg[SMBCFG_POWER_DOWN_ENABLE_BIT]) begin
      power_down_o <= lane_power_down_reg;
    end else begin
      power_down_o <= 8'h00;
    end
  end

  // Soft-reset bit self-clears, so it reads back as zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_reg <= SMBCFG_READ_UNMAPPED;
    end else begin
      rdata_reg <= SMBCFG_READ_UNMAPPED;
      if (bus.addr == SMBCFG_OFF_SOFT_RESET) rdata_reg <= SMBCFG_RST_SOFT_RESET;
      if (bus.addr == SMBCFG_OFF_LANE_POWER_DOWN) rdata_reg <= lane_power_down_reg;
      if (bus.addr == SMBCFG_OFF_POWER_DOWN_CTRL) rdata_reg <= power_down_ctrl_reg;
      for (int i = 0; i < SMBCFG_NUM_DEEMPH; i++) begin
        if (bus.addr == SMBCFG_OFF_DEEMPH[i]) rdata_reg <= deemph_reg[i];
      end
    end
  end
  assign bus.rdata = rdata_reg;
endmodule : smbcfg_regs

// ===== core/smbcfg_sync.sv
// Two-stage synchroniser for asynchronous pin levels.
// Assumes the output is read only in the clk_i domain.
`timescale 1ns/1ps
module smbcfg_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Level in and out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= INIT;
      q_o <= INIT;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule : smbcfg_sync

// ===== core/smbcfg_top.sv
// SMBus slave engine with configuration register file.
// Assumes an external host drives the serial clock; data is open drain.
`timescale 1ns/1ps
module smbcfg_top
  import smbcfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Mode and address select pins
  input wire logic smbus_mode_enable_i,
  input wire logic [3:0] address_select_pins_i,
  // Serial bus
  input wire logic serial_clock_pin_i,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  // Configuration outputs
  output logic [7:0] power_down_o,
  output logic [7:0] deemph_lane0_o,
  output logic [7:0] deemph_lane1_o,
  output logic [7:0] deemph_lane2_o,
  output logic [7:0] deemph_lane3_o,
  output logic [7:0] deemph_lane4_o,
  output logic [7:0] deemph_lane5_o,
  // Pin-mode settings stay live while not in smbus mode
  output logic [3:0] pin_settings_o,
  output logic bus_idle_o
);
  typedef enum logic [2:0] {
    SMBCFG_ST_IDLE = 3'b000,
    SMBCFG_ST_ADDR = 3'b001,
    SMBCFG_ST_ADDR_ACK = 3'b010,
    SMBCFG_ST_RX = 3'b011,
    SMBCFG_ST_RX_ACK = 3'b100,
    SMBCFG_ST_TX = 3'b101,
    SMBCFG_ST_TX_ACK = 3'b110,
    SMBCFG_ST_IGNORE = 3'b111
  } smbcfg_state_t;

  smbcfg_state_t state_reg;
  logic scl_s, sda_s, mode_s;
  logic [3:0] sel_s;
  logic scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic byte_done_reg;
  logic have_regaddr_reg;
  logic is_read_reg;
  logic [7:0] regaddr_reg;
  logic [7:0] tx_reg;
  logic [15:0] high_cnt_reg;
  logic after_stop_reg;
  logic wr_stb_reg;
  logic [7:0] wdata_reg;
  logic [7:0] deemph_w [SMBCFG_NUM_DEEMPH];
  logic [7:0] power_down_w;
  logic [6:0] my_addr;

  smbcfg_reg_if rif ();

  // Serial pins and mode enable cross into clk_i here
  smbcfg_sync #(.WIDTH(3), .INIT(3'b110)) u_sync_bus (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({serial_clock_pin_i, serial_data_i, smbus_mode_enable_i}),
    .q_o({scl_s, sda_s, mode_s})
  );

  // Select pins feed the slave address in smbus mode
  smbcfg_sync #(.WIDTH(4), .INIT(4'h0)) u_sync_sel (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i(address_select_pins_i),
    .q_o(sel_s)
  );

  function automatic logic [6:0] slave_addr(input logic [3:0] sel);
    slave_addr = SMBCFG_ADDR_BASE | {3'b000, sel};
  endfunction : slave_addr

  assign my_addr = slave_addr(mode_s ? sel_s : 4'h0);

  // Previous levels reset high, matching the idle bus
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Edges seen two cycles after the pins move
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_det = mode_s && scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // Idle timing
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      high_cnt_reg <= 16'h0000;
      after_stop_reg <= 1'b0;
      bus_idle_o <= 1'b1;
    end else begin
      if (stop_det) begin
        after_stop_reg <= 1'b1;
      end else if (start_det) begin
        after_stop_reg <= 1'b0;
      end
      if (!(scl_s && sda_s) || start_det) begin
        high_cnt_reg <= 16'h0000;
      end else if (high_cnt_reg != 16'hffff) begin
        high_cnt_reg <= high_cnt_reg + 16'h0001;
      end
      // Any low level ends idle; free time or max high restores it
      if (start_det || !(scl_s && sda_s)) begin
        bus_idle_o <= 1'b0;
      end else if ((after_stop_reg && high_cnt_reg >= 16'(SMBCFG_T_BUF_CYC)) ||
                   high_cnt_reg >= 16'(SMBCFG_T_HIGH_MAX_CYC)) begin
        bus_idle_o <= 1'b1;
      end
    end
  end

  // Protocol state machine
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= SMBCFG_ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      have_regaddr_reg <= 1'b0;
      is_read_reg <= 1'b0;
      regaddr_reg <= 8'h00;
      tx_reg <= 8'h00;
      wr_stb_reg <= 1'b0;
      wdata_reg <= 8'h00;
      byte_done_reg <= 1'b0;
      serial_data_o <= 1'b0;
      serial_data_oe_o <= 1'b0;
    end else begin
      // Write strobe lasts one cycle
      wr_stb_reg <= 1'b0;
      // Mode drop or stop abandons the transfer and frees the line
      if (!mode_s || stop_det) begin
        state_reg <= SMBCFG_ST_IDLE;
        serial_data_oe_o <= 1'b0;
      end else if (start_det) begin
        state_reg <= SMBCFG_ST_ADDR;
        bit_cnt_reg <= 3'h0;
        byte_done_reg <= 1'b0;
        have_regaddr_reg <= 1'b0;
        serial_data_oe_o <= 1'b0;
      end else begin
        case (state_reg)
          SMBCFG_ST_IDLE, SMBCFG_ST_IGNORE: begin
            serial_data_oe_o <= 1'b0;
          end
          SMBCFG_ST_ADDR, SMBCFG_ST_RX: begin
            // Byte complete on the eighth rise, whatever its value
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              byte_done_reg <= (bit_cnt_reg == 3'h7);
            end
            if (scl_fall && byte_done_reg) begin
              // Eight bits taken; decide on the falling edge
              byte_done_reg <= 1'b0;
              if (state_reg == SMBCFG_ST_ADDR) begin
                if (shift_reg[7:1] == my_addr) begin
                  is_read_reg <= shift_reg[0];
                  serial_data_oe_o <= 1'b1;
                  state_reg <= SMBCFG_ST_ADDR_ACK;
                end else begin
                  state_reg <= SMBCFG_ST_IGNORE;
                end
              end else begin
                if (!have_regaddr_reg) begin
                  regaddr_reg <= shift_reg;
                  have_regaddr_reg <= 1'b1;
                end else begin
                  wr_stb_reg <= 1'b1;
                  wdata_reg <= shift_reg;
                end
                serial_data_oe_o <= 1'b1;
                state_reg <= SMBCFG_ST_RX_ACK;
              end
            end
          end
          SMBCFG_ST_ADDR_ACK, SMBCFG_ST_RX_ACK: begin
            // Acknowledge released, or first read bit launched, on the fall
            if (scl_fall) begin
              shift_reg <= 8'h00;
              bit_cnt_reg <= 3'h0;
              if (state_reg == SMBCFG_ST_ADDR_ACK && is_read_reg) begin
                tx_reg <= rif.rdata;
                serial_data_oe_o <= !rif.rdata[7];
                bit_cnt_reg <= 3'h1;
                state_reg <= SMBCFG_ST_TX;
              end else begin
                serial_data_oe_o <= 1'b0;
                state_reg <= SMBCFG_ST_RX;
              end
            end
          end
          SMBCFG_ST_TX: begin
            // Bit count wraps to zero after the last bit
            if (scl_fall) begin
              if (bit_cnt_reg == 3'h0) begin
                serial_data_oe_o <= 1'b0;
                state_reg <= SMBCFG_ST_TX_ACK;
              end else begin
                serial_data_oe_o <= !tx_reg[3'h7 - bit_cnt_reg];
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
              end
            end
          end
          SMBCFG_ST_TX_ACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state_reg <= SMBCFG_ST_IGNORE;
              end else begin
                regaddr_reg <= regaddr_reg + 8'h01;
              end
            end
            // Still here at the fall means the host acknowledged
            if (scl_fall) begin
              tx_reg <= rif.rdata;
              serial_data_oe_o <= !rif.rdata[7];
              bit_cnt_reg <= 3'h1;
              state_reg <= SMBCFG_ST_TX;
            end
          end
          default: begin
            state_reg <= SMBCFG_ST_IDLE;
          end
        endcase
      end
    end
  end

  // Register port
  assign rif.wr_stb = wr_stb_reg;
  assign rif.addr = regaddr_reg;
  assign rif.wdata = wdata_reg;

  // Register file sees the synchronised mode level
  smbcfg_regs u_regs (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .mode_enable_i(mode_s),
    .bus(rif),
    .power_down_o(power_down_w),
    .deemph_o(deemph_w)
  );

  // Every top output leaves from a flop
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      power_down_o <= 8'h00;
      deemph_lane0_o <= SMBCFG_RST_DEEMPH;
      deemph_lane1_o <= SMBCFG_RST_DEEMPH;
      deemph_lane2_o <= SMBCFG_RST_DEEMPH;
      deemph_lane3_o <= SMBCFG_RST_DEEMPH;
      deemph_lane4_o <= SMBCFG_RST_DEEMPH;
      deemph_lane5_o <= SMBCFG_RST_DEEMPH;
      pin_settings_o <= 4'h0;
    end else begin
      power_down_o <= power_down_w;
      deemph_lane0_o <= deemph_w[0];
      deemph_lane1_o <= deemph_w[1];
      deemph_lane2_o <= deemph_w[2];
      deemph_lane3_o <= deemph_w[3];
      deemph_lane4_o <= deemph_w[4];
      deemph_lane5_o <= deemph_w[5];
      pin_settings_o <= mode_s ? 4'h0 : sel_s;
    end
  end
endmodule : smbcfg_top

// ===== bench/smbcfg_checker.sv
// Port-level checks for the SMBus configuration slave.
// Assumes one clock domain; bound onto the top module below.
`timescale 1ns/1ps
module smbcfg_checker
  import smbcfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Watched ports
  input wire logic smbus_mode_enable_i,
  input wire logic [3:0] address_select_pins_i,
  input wire logic serial_clock_pin_i,
  input wire logic serial_data_i,
  input wire logic serial_data_o,
  input wire logic serial_data_oe_o,
  input wire logic [7:0] power_down_o,
  input wire logic [7:0] deemph_lane0_o,
  input wire logic [3:0] pin_settings_o,
  input wire logic bus_idle_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  int hi_cnt;
  // Cycles with both serial lines high
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i)
      hi_cnt <= 0;
    else if (serial_clock_pin_i && serial_data_i)
      hi_cnt <= hi_cnt + 1;
    else
      hi_cnt <= 0;
  end
  sequence s_start;
    smbus_mode_enable_i && serial_clock_pin_i && $past(serial_clock_pin_i) && $fell(serial_data_i);
  endsequence
  sequence s_busy;
    ##[1:8] !bus_idle_o;
  endsequence
  a_drive_low_only: assert property (serial_data_oe_o |-> !serial_data_o)
    else $error("data line driven high");
  a_quiet_mode_off: assert property (!smbus_mode_enable_i [*6] |-> !serial_data_oe_o)
    else $error("data line driven outside smbus mode");
  a_change_scl_low: assert property ($changed(serial_data_oe_o) |-> !serial_clock_pin_i)
    else $error("data changed while clock high");
  a_ack_holds: assert property ($rose(serial_data_oe_o) |-> serial_data_oe_o [*8])
    else $error("driven bit too short");
  a_busy_on_start: assert property (s_start |-> s_busy)
    else $error("start not seen");
  a_idle_timeout: assert property (hi_cnt > SMBCFG_T_BUF_CYC + 8 |-> bus_idle_o)
    else $error("bus not idle after free time");
  a_regs_cleared: assert property (!smbus_mode_enable_i [*6] |->
      power_down_o == 8'h00 && deemph_lane0_o == 8'h00)
    else $error("registers kept outside smbus mode");
  a_pins_pass: assert property ((!smbus_mode_enable_i && $stable(address_select_pins_i)) [*5]
      |-> pin_settings_o == address_select_pins_i)
    else $error("pin settings not passed");
  a_pins_muted: assert property (smbus_mode_enable_i [*5] |-> pin_settings_o == 4'h0)
    else $error("pin settings live in smbus mode");
  a_cfg_quiet_idle: assert property ($changed(deemph_lane0_o) && smbus_mode_enable_i
      && $past(smbus_mode_enable_i, 6) |-> !bus_idle_o)
    else $error("register changed with bus idle");
endmodule : smbcfg_checker
bind smbcfg_top smbcfg_checker u_chk (.clk_i, .reset_i, .smbus_mode_enable_i,
  .address_select_pins_i, .serial_clock_pin_i, .serial_data_i, .serial_data_o,
  .serial_data_oe_o, .power_down_o, .deemph_lane0_o, .pin_settings_o, .bus_idle_o);

// ===== bench/smbcfg_host.sv
// Behavioural SMBus host: clock master, open-drain data driver.
// Assumes the data line is pulled up and resolved by the bench.
`timescale 1ns/1ps
module smbcfg_host (
  // Serial bus
  output logic scl_o,
  output logic sda_oe_o,
  input wire logic sda_i
);
  localparam realtime Q = 31.25;
  // Clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic bit_x(input logic b, output logic r);
    #Q sda_oe_o = ~b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
  endtask : bit_x
  task automatic start_c();
    #Q sda_oe_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_oe_o = 1'b1;
    #Q scl_o = 1'b0;
  endtask : start_c
  task automatic stop_c();
    #Q sda_oe_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_oe_o = 1'b0;
    #Q;
  endtask : stop_c
  task automatic tx(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : tx
  task automatic write_reg(input logic [6:0] a, input logic [7:0] ra, wd, output logic ok);
    logic k0, k1, k2;
    start_c();
    tx({a, 1'b0}, k0);
    tx(ra, k1);
    tx(wd, k2);
    stop_c();
    ok = k0 & k1 & k2;
  endtask : write_reg
  task automatic read_reg(input logic [6:0] a, input logic [7:0] ra, output logic [7:0] rd,
      output logic ok);
    logic k0, k1, k2, r;
    start_c();
    tx({a, 1'b0}, k0);
    tx(ra, k1);
    start_c();
    tx({a, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) bit_x(1'b1, rd[i]);
    bit_x(1'b1, r);
    stop_c();
    ok = k0 & k1 & k2;
  endtask : read_reg
  task automatic read_two(input logic [6:0] a, input logic [7:0] ra, output logic [15:0] rd,
      output logic ok);
    logic k0, k1, k2, r;
    start_c();
    tx({a, 1'b0}, k0);
    tx(ra, k1);
    start_c();
    tx({a, 1'b1}, k2);
    for (int i = 15; i >= 8; i--) bit_x(1'b1, rd[i]);
    bit_x(1'b0, r);
    for (int i = 7; i >= 0; i--) bit_x(1'b1, rd[i]);
    bit_x(1'b1, r);
    stop_c();
    ok = k0 & k1 & k2;
  endtask : read_two
endmodule : smbcfg_host

// ===== bench/test_smbus_config_slave.sv
// Self-checking bench for the configuration slave and its host model.
// Assumes core and bench files are compiled together.
`timescale 1ns/1ps
module test_smbus_config_slave
  import smbcfg_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mode = 1'b1;
  logic [3:0] pins = 4'h0;
  logic scl, host_oe, dut_oe, sda_o, idle;
  logic [7:0] pd;
  logic [7:0] de [SMBCFG_NUM_DEEMPH];
  logic [3:0] pset;
  wire sda = ~(dut_oe | host_oe);
  int bad_count = 0;
  int tests_run = 0;
  logic [7:0] codes [5] = '{8'h01, 8'he8, 8'h88, 8'h90, 8'ha0};
  logic [7:0] eq_off [6] = '{8'h0f, 8'h16, 8'h1d, 8'h24, 8'h2c, 8'h3a};
  logic [7:0] sw_off [6] = '{8'h17, 8'h25, 8'h2d, 8'h34, 8'h3b, 8'h42};
  always #5 clk = ~clk;
  smbcfg_top dut (.clk_i(clk), .reset_i(rst), .smbus_mode_enable_i(mode),
    .address_select_pins_i(pins), .serial_clock_pin_i(scl), .serial_data_i(sda),
    .serial_data_o(sda_o), .serial_data_oe_o(dut_oe), .power_down_o(pd),
    .deemph_lane0_o(de[0]), .deemph_lane1_o(de[1]), .deemph_lane2_o(de[2]),
    .deemph_lane3_o(de[3]), .deemph_lane4_o(de[4]), .deemph_lane5_o(de[5]),
    .pin_settings_o(pset), .bus_idle_o(idle));
  smbcfg_host host (.scl_o(scl), .sda_oe_o(host_oe), .sda_i(sda));
  task automatic chk(input logic [7:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [6:0] a, input logic [7:0] ra, wd, input logic exp_ok);
    logic ok;
    host.write_reg(a, ra, wd, ok);
    chk({7'h0, ok}, {7'h0, exp_ok}, "write ack");
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] ra, exp);
    logic ok;
    logic [7:0] d;
    host.read_reg(a, ra, d, ok);
    chk({7'h0, ok}, 8'h01, "read ack");
    chk(d, exp, "read data");
  endtask : rd
  task automatic rd2(input logic [6:0] a, input logic [7:0] ra, input logic [15:0] exp);
    logic ok;
    logic [15:0] d;
    host.read_two(a, ra, d, ok);
    chk({7'h0, ok}, 8'h01, "burst read ack");
    chk(d[15:8], exp[15:8], "burst first byte");
    chk(d[7:0], exp[7:0], "burst second byte");
  endtask : rd2
  task automatic t_codes();
    for (int i = 0; i < 6; i++) wr(7'b1010000, SMBCFG_OFF_DEEMPH[i], codes[i % 5], 1'b1);
    cyc(5);
    for (int i = 0; i < 6; i++) chk(de[i], codes[i % 5], "lane code");
    rd(7'b1010000, SMBCFG_OFF_DEEMPH[4], codes[4]);
    $display("t_codes done, mismatches %0d", bad_count);
  endtask : t_codes
  task automatic t_power_down();
    rd(7'b1010000, 8'h01, 8'h00);
    wr(7'b1010000, 8'h01, 8'hff, 1'b1);
    cyc(5);
    chk(pd, 8'h00, "gated power-down");
    rd(7'b1010000, 8'h01, 8'hff);
    wr(7'b1010000, 8'h02, 8'h01, 1'b1);
    cyc(5);
    chk(pd, 8'hff, "all paths down");
    wr(7'b1010000, 8'h01, 8'h5a, 1'b1);
    cyc(5);
    chk(pd, 8'h5a, "some paths down");
    rd2(7'b1010000, 8'h01, {8'h5a, 8'h01});
    $display("t_power_down done, mismatches %0d", bad_count);
  endtask : t_power_down
  task automatic t_init();
    wr(7'b1010000, 8'h00, 8'h01, 1'b1);
    cyc(5);
    chk(pd, 8'h00, "power-down after soft reset");
    chk(de[1], 8'h00, "lane after soft reset");
    rd(7'b1010000, 8'h01, 8'h00);
    rd(7'b1010000, 8'h00, 8'h00);
    for (int i = 0; i < 6; i++) wr(7'b1010000, SMBCFG_OFF_DEEMPH[i], 8'h88, 1'b1);
    for (int i = 0; i < 6; i++) wr(7'b1010000, eq_off[i], 8'h30, 1'b1);
    for (int i = 0; i < 6; i++) wr(7'b1010000, sw_off[i], 8'h0f, 1'b1);
    for (int i = 0; i < 6; i++) chk(de[i], 8'h88, "lane after init");
    rd(7'b1010000, eq_off[0], 8'h00);
    $display("t_init done, mismatches %0d", bad_count);
  endtask : t_init
  task automatic t_mode();
    @(posedge clk);
    mode <= 1'b0;
    pins <= 4'h9;
    cyc(10);
    chk({4'h0, pset}, 8'h09, "pin settings");
    chk(de[0], 8'h00, "lane with mode low");
    wr(7'b1011001, 8'h18, 8'h01, 1'b0);
    @(posedge clk);
    mode <= 1'b1;
    cyc(10);
    chk({4'h0, pset}, 8'h00, "pin settings muted");
    wr(7'b1011001, 8'h18, 8'h01, 1'b1);
    wr(7'b1010000, 8'h18, 8'h90, 1'b0);
    cyc(5);
    chk(de[0], 8'h01, "lane after foreign write");
    rd(7'b1011001, 8'h18, 8'h01);
    $display("t_mode done, mismatches %0d", bad_count);
  endtask : t_mode
  task automatic t_idle();
    int n;
    cyc(SMBCFG_T_BUF_CYC - 100);
    chk({7'h0, idle}, 8'h00, "busy before free time");
    n = 0;
    while (idle !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk({7'h0, idle}, 8'h01, "idle after free time");
    $display("t_idle done, mismatches %0d", bad_count);
  endtask : t_idle
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    cyc(12);
    rst <= 1'b0;
    cyc(8);
    t_codes();
    t_power_down();
    t_init();
    t_mode();
    t_idle();
    report_and_stop();
  end
endmodule : test_smbus_config_slave
